// ---- rtl/pwm_irq_pkg.sv ----
// Constants, types and register map of the pwm interrupt and readback block
// How it works
// - Status bits stay set until software writes one there; zero leaves them.
// - Status bit 0 sets when channel 0 pulse counter equals programmed pulse number.
// - Status bit 1 sets on pulse-number event while IR DMA FIFO mode and FIFO empty.
// - Status bit 2 sets when channel 0 counter reaches its cycle maximum.
// - Status bits 3 to 7 set on cycle completion of channels 1 to 5.
// - Enable bits 3 to 7 gate channel 1 to 5 frame interrupts; 1 enables.
`default_nettype none

package pwm_irq_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int CNT_W = 16;
    localparam int NUM_CH = 6;
    localparam int ADDR_W = 13;
    localparam int IDX_W = 11;
    localparam int BYTE_W = 8;

    // ****************************************************************
    // Register indices; byte address is four times the index
    // ****************************************************************
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 11'h7b2;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 11'h7b3;
    localparam logic [IDX_W-1:0] IDX_CNT0_LOW = 11'h7b4;
    localparam logic [IDX_W-1:0] IDX_CNT5_LOW = 11'h7be;
    localparam logic [IDX_W-1:0] IDX_CNT5_HIGH = 11'h7bf;
    localparam logic [IDX_W-1:0] IDX_PCNT0_LOW = 11'h7c0;
    localparam logic [IDX_W-1:0] IDX_PCNT0_HIGH = 11'h7c1;
    localparam logic [IDX_W-1:0] IDX_SPARE_LO = 11'h7c2;
    localparam logic [IDX_W-1:0] IDX_SPARE_HI = 11'h7c3;

    // ****************************************************************
    // Status and enable bit positions, reset values, responses
    // ****************************************************************
    localparam int BIT_PULSE_DONE = 0;
    localparam int BIT_FIFO_DONE = 1;
    localparam int BIT_CH0_CYCLE = 2;
    localparam int BIT_CH1_CYCLE = 3;
    localparam logic [BYTE_W-1:0] STATUS_RST = 8'h00;
    localparam logic [BYTE_W-1:0] ENABLE_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Per-channel view of the counting logic
    typedef struct packed {
        logic [CNT_W-1:0] counter;
        logic [CNT_W-1:0] cycle_maximum;
    } chan_view_s;

    // Channel 0 pulse-number view
    typedef struct packed {
        logic [CNT_W-1:0] emitted_pulse_counter;
        logic [CNT_W-1:0] pulse_number;
        logic ir_dma_fifo_mode;
        logic fifo_empty;
    } pulse_view_s;

endpackage

`default_nettype wire

// ---- rtl/pwm_irq_readback.sv ----
// Interrupt status, enable and counter readback of the six-channel pwm unit
//
// Design decision made here: the AXI4-Lite interface to the registers.
`default_nettype none

module pwm_irq_readback #(
    parameter int NUM_CH = pwm_irq_pkg::NUM_CH,
    parameter int CNT_W = pwm_irq_pkg::CNT_W
) (
    input wire logic aclk, // System clock, 50 MHz
    input wire logic aresetn, // Synchronous reset, active low
    // Counting logic of the unit
    input wire pwm_irq_pkg::chan_view_s [5:0] chan_view, // Counter and cycle max per channel
    input wire pwm_irq_pkg::pulse_view_s pulse_view, // Channel 0 pulse state
    // AXI4-Lite write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [pwm_irq_pkg::ADDR_W-1:0] awaddr, // Write byte address
    input wire logic [2:0] awprot, // Protection, unused
    // AXI4-Lite write data
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Byte strobes
    // AXI4-Lite write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    output logic [1:0] bresp, // Write response
    // AXI4-Lite read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    input wire logic [pwm_irq_pkg::ADDR_W-1:0] araddr, // Read byte address
    input wire logic [2:0] arprot, // Protection, unused
    // AXI4-Lite read data
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    // Interrupt
    output logic irq // Level, high while an enabled status bit is set
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Status byte maps exactly six channels plus the pulse and FIFO bits
    if (NUM_CH != pwm_irq_pkg::NUM_CH) begin : g_bad_ch
        $error("pwm_irq_readback: channel count must be six");
    end
    if (CNT_W != pwm_irq_pkg::CNT_W) begin : g_bad_w
        $error("pwm_irq_readback: counter width must be sixteen");
    end
    // Byte lanes of the read data assume eight-bit registers
    if (pwm_irq_pkg::BYTE_W != 8) begin : g_bad_byte
        $error("pwm_irq_readback: register bytes must be eight bits");
    end

    // Map arithmetic: counter pairs are found by offset, so the
    // package indices must form one unbroken run
    localparam int CNT_SPAN = 2 * NUM_CH;
    localparam int MAP_STATUS = int'(pwm_irq_pkg::IDX_IRQ_STATUS);
    localparam int MAP_LO = int'(pwm_irq_pkg::IDX_CNT0_LOW);
    localparam int MAP_CNT5 = int'(pwm_irq_pkg::IDX_CNT5_LOW);
    localparam int MAP_PCNT = int'(pwm_irq_pkg::IDX_PCNT0_LOW);
    // Counters follow the status byte directly
    if (MAP_LO != MAP_STATUS + 1) begin : g_bad_lo
        $error("pwm_irq_readback: counters must follow the status byte");
    end
    // Last channel pair must sit where the offset arithmetic puts it
    if (MAP_CNT5 != MAP_LO + CNT_SPAN - 2) begin : g_bad_cnt5
        $error("pwm_irq_readback: last counter pair out of place");
    end
    // Pulse count starts right after the last counter pair
    if (MAP_PCNT != MAP_LO + CNT_SPAN) begin : g_bad_pcnt
        $error("pwm_irq_readback: pulse count must follow the counters");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] enable_r;
    logic [7:0] enable_nxt;
    logic [7:0] event_set;
    logic [7:0] write_clear;
    logic [NUM_CH-1:0] cycle_hit;
    logic [NUM_CH-1:0] cycle_hit_r;
    logic pulse_hit;
    logic pulse_hit_r;
    logic pulse_event;
    logic irq_r;
    logic irq_nxt;

    logic aw_held_r;
    logic w_held_r;
    logic [pwm_irq_pkg::IDX_W-1:0] aw_idx_r;
    logic [7:0] w_byte_r;
    logic w_lane0_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic aw_take;
    logic w_take;
    logic wr_go;
    logic wr_hit_enable;
    logic wr_hit_status;
    logic wr_mapped;
    logic [1:0] wr_resp;

    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic ar_take;
    logic [pwm_irq_pkg::IDX_W-1:0] ar_idx;
    logic [pwm_irq_pkg::IDX_W-1:0] cnt_off;
    logic rd_is_cnt;
    logic rd_is_pcnt;
    logic rd_is_spare;
    logic rd_mapped;
    logic [2:0] rd_chan;
    logic [CNT_W-1:0] rd_cnt_word;
    logic [CNT_W-1:0] rd_pcnt_word;
    logic [7:0] rd_byte;
    logic [NUM_CH-1:0] cycle_event;
    logic fifo_event;
    logic rd_hit_enable;
    logic rd_hit_status;
    logic rd_pcnt_high;
    logic [7:0] rd_cnt_byte;
    logic [7:0] rd_pcnt_byte;

    // ****************************************************************
    // Event detection
    // ****************************************************************
    // Compares are level; a bit is set only on the cycle a compare
    // starts to match, so a counter parked at its maximum counts once
    genvar gi;
    for (gi = 0; gi < NUM_CH; gi++) begin : g_cycle
        assign cycle_hit[gi] = chan_view[gi].counter == chan_view[gi].cycle_maximum;
    end

    assign pulse_hit = pulse_view.emitted_pulse_counter == pulse_view.pulse_number;
    assign pulse_event = pulse_hit & ~pulse_hit_r;

    // Rising edge of each compare; the FIFO bit also needs FIFO mode and empty
    assign cycle_event = cycle_hit & ~cycle_hit_r;
    assign fifo_event = pulse_event
        & pulse_view.ir_dma_fifo_mode & pulse_view.fifo_empty;

    // Status bit sources
    assign event_set[pwm_irq_pkg::BIT_PULSE_DONE] = pulse_event;
    assign event_set[pwm_irq_pkg::BIT_FIFO_DONE] = fifo_event;
    assign event_set[pwm_irq_pkg::BIT_CH0_CYCLE] = cycle_event[0];
    assign event_set[7:pwm_irq_pkg::BIT_CH1_CYCLE] = cycle_event[NUM_CH-1:1];

    // Compare history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cycle_hit_r <= '0;
            pulse_hit_r <= 1'b0;
        end else begin
            cycle_hit_r <= cycle_hit;
            pulse_hit_r <= pulse_hit;
        end
    end

    // ****************************************************************
    // Status and enable registers
    // ****************************************************************
    // Write one clears; an event in the same cycle wins over the clear
    assign write_clear = (wr_go && wr_hit_status && w_lane0_r) ? w_byte_r : 8'h00;
    assign status_nxt = (status_r & ~write_clear) | event_set;
    assign enable_nxt = (wr_go && wr_hit_enable && w_lane0_r) ? w_byte_r : enable_r;
    // Enable gates each status bit onto the single interrupt line
    assign irq_nxt = |(status_nxt & enable_nxt);

    // Sticky status, enables and the interrupt flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= pwm_irq_pkg::STATUS_RST;
            enable_r <= pwm_irq_pkg::ENABLE_RST;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            enable_r <= enable_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    // Address and data are caught independently, in either order
    assign aw_take = awvalid & awready_r;
    assign w_take = wvalid & wready_r;
    assign wr_go = aw_held_r & w_held_r & ~bvalid_r;

    // Write decode; read-only and spare words accept writes silently
    assign wr_hit_enable = aw_idx_r == pwm_irq_pkg::IDX_IRQ_ENABLE;
    assign wr_hit_status = aw_idx_r == pwm_irq_pkg::IDX_IRQ_STATUS;
    assign wr_mapped = (aw_idx_r >= pwm_irq_pkg::IDX_IRQ_ENABLE)
        && (aw_idx_r <= pwm_irq_pkg::IDX_SPARE_HI);
    assign wr_resp = wr_mapped ? pwm_irq_pkg::RESP_OKAY : pwm_irq_pkg::RESP_SLVERR;

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_idx_r <= '0;
            awready_r <= 1'b1;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_idx_r <= awaddr[pwm_irq_pkg::ADDR_W-1:2];
            awready_r <= 1'b0;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end else if (bvalid_r && bready) begin
            awready_r <= 1'b1;
        end
    end

    // Write data capture; only the low lane carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_byte_r <= '0;
            w_lane0_r <= 1'b0;
            wready_r <= 1'b1;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            w_byte_r <= wdata[7:0];
            w_lane0_r <= wstrb[0];
            wready_r <= 1'b0;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end else if (bvalid_r && bready) begin
            wready_r <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= pwm_irq_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_resp;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    assign ar_take = arvalid & arready_r;
    assign ar_idx = araddr[pwm_irq_pkg::ADDR_W-1:2];

    // Counter words 0..5 sit in pairs, low byte first
    assign cnt_off = ar_idx - pwm_irq_pkg::IDX_CNT0_LOW;
    assign rd_is_cnt = (ar_idx >= pwm_irq_pkg::IDX_CNT0_LOW)
        && (ar_idx <= pwm_irq_pkg::IDX_CNT5_HIGH);
    assign rd_is_pcnt = (ar_idx == pwm_irq_pkg::IDX_PCNT0_LOW)
        || (ar_idx == pwm_irq_pkg::IDX_PCNT0_HIGH);
    assign rd_is_spare = (ar_idx == pwm_irq_pkg::IDX_SPARE_LO)
        || (ar_idx == pwm_irq_pkg::IDX_SPARE_HI);
    assign rd_hit_enable = ar_idx == pwm_irq_pkg::IDX_IRQ_ENABLE;
    assign rd_hit_status = ar_idx == pwm_irq_pkg::IDX_IRQ_STATUS;
    assign rd_pcnt_high = ar_idx == pwm_irq_pkg::IDX_PCNT0_HIGH;
    assign rd_mapped = rd_is_cnt || rd_is_pcnt || rd_is_spare
        || rd_hit_enable || rd_hit_status;
    assign rd_chan = cnt_off[3:1];
    // Out-of-range channel only arises on unselected addresses
    assign rd_cnt_word = (rd_chan < 3'(NUM_CH)) ? chan_view[rd_chan].counter : '0;
    assign rd_pcnt_word = pulse_view.emitted_pulse_counter;

    // Halves of the live words; no latching, so a 16-bit value read as
    // two bytes may tear while the counter runs
    assign rd_cnt_byte = cnt_off[0] ? rd_cnt_word[15:8] : rd_cnt_word[7:0];
    assign rd_pcnt_byte = rd_pcnt_high ? rd_pcnt_word[15:8] : rd_pcnt_word[7:0];

    // Byte selection; reads are pure, nothing in the counters moves
    assign rd_byte = rd_hit_enable ? enable_r
        : rd_hit_status ? status_r
        : rd_is_cnt ? rd_cnt_byte
        : rd_is_pcnt ? rd_pcnt_byte
        : 8'h00;

    // Read address accept and data return
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= pwm_irq_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_byte};
            rresp_r <= rd_mapped ? pwm_irq_pkg::RESP_OKAY : pwm_irq_pkg::RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Outputs, all straight from flops
    // ****************************************************************
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign irq = irq_r;

endmodule // pwm_irq_readback

`default_nettype wire

// ---- test/pwm_irq_readback_sva.sv ----
// Bus timing checker for the pwm interrupt and readback block
`default_nettype none

module pwm_irq_readback_chk (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic awvalid, // Write address valid
    input wire logic awready, // Write address ready
    input wire logic wvalid, // Write data valid
    input wire logic wready, // Write data ready
    input wire logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [1:0] bresp, // Write response
    input wire logic arvalid, // Read address valid
    input wire logic arready, // Read address ready
    input wire logic [pwm_irq_pkg::ADDR_W-1:0] araddr, // Read address
    input wire logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic [31:0] rdata, // Read data
    input wire logic [1:0] rresp // Read response
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Handshake and response checks
    // ****************************************************************
    // One domain, so clock and reset are declared once
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_b_latency: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
        else $error("write response not two edges after take");
    chk_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    chk_w_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write channels ready during open response");
    chk_r_latency: assert property (arvalid && arready |=> rvalid)
        else $error("read data not one edge after take");
    chk_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data changed before rready");
    chk_ar_refused: assert property (rvalid |-> !arready)
        else $error("read address ready during open read");
    chk_r_byte: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_rd_unmapped: assert property (arvalid && arready
        && araddr[12:2] < pwm_irq_pkg::IDX_IRQ_ENABLE |=> rresp == pwm_irq_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");
endmodule // pwm_irq_readback_chk

bind pwm_irq_readback pwm_irq_readback_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

`default_nettype wire

// ---- test/pwm_irq_readback_tb.sv ----
// Self-checking bench for the pwm interrupt and readback block
`default_nettype none

module pwm_irq_readback_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [12:0] awaddr, araddr, st, en;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, ok;
    logic [3:0] wstrb;
    logic [15:0] v;
    logic [7:0] e;
    pwm_irq_pkg::chan_view_s [5:0] chan_view;
    pwm_irq_pkg::pulse_view_s pulse_view;
    int bad_count, cmp_count, k, b;

    pwm_irq_readback i_dut (.aclk(aclk), .aresetn(aresetn), .chan_view(chan_view),
        .pulse_view(pulse_view), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .irq(irq));

    // 50 MHz clock
    always #10 aclk = ~aclk;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [12:0] ba(input logic [10:0] i);
        return {i, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Bounded waits: a bus that never answers ends the run
    task automatic hang();
        bad_count++;
        $display("mismatch at %0t: no bus answer", $time);
        end_sim();
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) hang();
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [12:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) hang();
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        st = ba(pwm_irq_pkg::IDX_IRQ_STATUS);
        en = ba(pwm_irq_pkg::IDX_IRQ_ENABLE);
        ok = pwm_irq_pkg::RESP_OKAY;
        aresetn <= 1'b0;
        {awvalid, wvalid, arvalid} <= 3'h0;
        // Responses always accepted, so no ready toggles between calls
        {bready, rready} <= 2'h3;
        {awaddr, araddr, wdata} <= '0;
        wstrb <= 4'hf;
        // Compares held unequal so no event fires at release
        chan_view <= {6{pwm_irq_pkg::chan_view_s'{16'h0000, 16'hfffe}}};
        pulse_view <= pwm_irq_pkg::pulse_view_s'{16'h0000, 16'hfffe, 1'b0, 1'b0};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(st, {24'h0, pwm_irq_pkg::STATUS_RST}, ok);
        rd(en, {24'h0, pwm_irq_pkg::ENABLE_RST}, ok);
        // Live counter bytes, read twice to show reads leave them alone
        for (k = 0; k < 6; k++) chan_view[k].counter <= 16'h1234 + 16'(k) * 16'h1111;
        pulse_view.emitted_pulse_counter <= 16'h0a5c;
        for (k = 0; k < 12; k++) begin
            v = 16'h1234 + 16'(k % 6) * 16'h1111;
            rd(ba(pwm_irq_pkg::IDX_CNT0_LOW + 11'(2 * (k % 6))), {24'h0, v[7:0]}, ok);
            rd(ba(pwm_irq_pkg::IDX_CNT0_LOW + 11'(2 * (k % 6) + 1)), {24'h0, v[15:8]}, ok);
        end
        wr(ba(pwm_irq_pkg::IDX_PCNT0_LOW), 32'hff, ok);
        rd(ba(pwm_irq_pkg::IDX_PCNT0_LOW), 32'h5c, ok);
        rd(ba(pwm_irq_pkg::IDX_PCNT0_HIGH), 32'h0a, ok);
        rd(ba(pwm_irq_pkg::IDX_SPARE_LO), 32'h0, ok);
        rd(13'h0004, 32'h0, pwm_irq_pkg::RESP_SLVERR);
        wr(13'h0004, 32'hff, pwm_irq_pkg::RESP_SLVERR);
        // Each event source in turn, with write-zero and write-one clears
        wr(en, 32'hff, ok);
        for (b = 0; b < 8; b++) begin
            e = (b == 1) ? 8'h03 : 8'h01 << b;
            if (b < 2) begin
                pulse_view.ir_dma_fifo_mode <= (b == 1);
                pulse_view.fifo_empty <= 1'b1;
                pulse_view.emitted_pulse_counter <= 16'hfffe;
            end else chan_view[b-2].counter <= 16'hfffe;
            repeat (2) @(posedge aclk);
            rd(st, {24'h0, e}, ok);
            chk({31'h0, irq}, 32'h1);
            wr(st, 32'h0, ok);
            rd(st, {24'h0, e}, ok);
            wr(st, {24'h0, e}, ok);
            rd(st, 32'h0, ok);
            chk({31'h0, irq}, 32'h0);
            pulse_view.emitted_pulse_counter <= 16'h0;
            for (k = 0; k < 6; k++) chan_view[k].counter <= 16'h0;
            // One edge with compares unequal, so the next match is a fresh edge
            @(posedge aclk);
        end
        // Masked channel 1 event stays silent until enabled
        wr(en, 32'hf7, ok);
        chan_view[1].counter <= 16'hfffe;
        repeat (2) @(posedge aclk);
        rd(st, 32'h08, ok);
        chk({31'h0, irq}, 32'h0);
        wr(en, 32'h08, ok);
        chk({31'h0, irq}, 32'h1);
        // Write with the low strobe off leaves the mask alone
        wstrb <= 4'he;
        wr(en, 32'h0, ok);
        wstrb <= 4'hf;
        rd(en, 32'h08, ok);
        chk({31'h0, irq}, 32'h1);
        end_sim();
    end
endmodule // pwm_irq_readback_tb

`default_nettype wire
